/* shared/ppr_consts.svh */
`ifndef PPR_CONSTS_SVH
`define PPR_CONSTS_SVH

// register map, byte addresses on the wishbone slave
`define PPR_ADR_W         9
`define PPR_IN_BASE       9'h000
`define PPR_OUT_BASE      9'h080
`define PPR_STAT_OFS      9'h100
`define PPR_LVL_OFS       9'h104

// reset values of the select fields
`define PPR_ISEL_RST      7'h00
`define PPR_OSEL_RST      6'h00

// input select codes
`define PPR_ISEL_GND      7'h00
`define PPR_ISEL_CMP1     7'h01
`define PPR_ISEL_CMP2     7'h02
`define PPR_ISEL_CMP3     7'h03
`define PPR_ISEL_CMP4     7'h04
`define PPR_ISEL_TRG30    7'h06
`define PPR_ISEL_TRG31    7'h07
`define PPR_ISEL_FIDX     7'h08
`define PPR_ISEL_FHOME    7'h09
`define PPR_ISEL_MAX      7'h79

// output select codes
`define PPR_OSEL_PORT     6'h00
`define PPR_OSEL_UART1_TX 6'h01
`define PPR_OSEL_UART2_TX 6'h03
`define PPR_OSEL_SPI_DATA 6'h08
`define PPR_OSEL_SPI_CLK  6'h09
`define PPR_OSEL_SPI_SEL  6'h0A
`define PPR_OSEL_CAN_TX   6'h0E
`define PPR_OSEL_CMPR1    6'h10
`define PPR_OSEL_CMPR2    6'h11
`define PPR_OSEL_CMPR3    6'h12
`define PPR_OSEL_CMPR4    6'h13
`define PPR_OSEL_CMP1     6'h18
`define PPR_OSEL_CMP2     6'h19
`define PPR_OSEL_CMP3     6'h1A
`define PPR_OSEL_TB_SYNC  6'h2D
`define PPR_OSEL_ENC_CMP  6'h2F
`define PPR_OSEL_REFCLK   6'h31
`define PPR_OSEL_CMP4     6'h32

`endif

/* shared/ppr_pkg.sv */
`default_nettype none
package ppr_pkg;

  typedef logic [6:0] ppr_isel_t;
  typedef logic [5:0] ppr_osel_t;

  // one entry per remappable peripheral input, also its register slot
  typedef enum {
    PPRI_EXT_IRQ1, PPRI_EXT_IRQ2, PPRI_TMR2_CLK, PPRI_CAP1, PPRI_CAP2, PPRI_CAP3, PPRI_CAP4,
    PPRI_CMP_FAULT, PPRI_PWM_FAULT1, PPRI_PWM_FAULT2, PPRI_ENC_A, PPRI_ENC_B, PPRI_ENC_INDEX,
    PPRI_ENC_HOME, PPRI_UART1_RX, PPRI_UART2_RX, PPRI_SPI_DIN, PPRI_SPI_CLK, PPRI_SPI_SEL,
    PPRI_CAN_RX, PPRI_PWM_SYNC, PPRI_DTC1, PPRI_DTC2, PPRI_DTC3, PPRI_COUNT
  } ppr_in_idx_t;

endpackage : ppr_pkg
`default_nettype wire

/* src/ppr_remap.sv */
// The implementer's own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ppr_consts.svh"

// Behaviour
// R1 - separate input and output select sets
// R2 - one 7-bit select per peripheral input
// R3 - input code n selects pin n
// R4 - only present pin codes are meaningful
// R5 - codes for ground, comparators, trigger outputs
// R6 - motor variant: filtered index and home codes
// R7 - pin code equals pin number, max 121
// R8 - virtual internal sources drive peripheral inputs
// R9 - software enables encoder filter for reuse
// R10 - input fields for all listed peripheral inputs
// R11 - one 6-bit select per bidirectional pin
// R12 - output code zero keeps port function
// R13 - serial output codes: uart, spi, can
// R14 - codes drive compare channels one to four
// R15 - codes drive comparator outputs onto pin
// R16 - sync, encoder match, reference clock codes
// R17 - output selects reset to zero
// R18 - no lockout between fields
// R19 - one-to-many and many-to-one allowed
// R20 - inputs unconnected until software assigns
// R21 - remapped output beats digital, never analog
// R22 - absent input source reads low
// R23 - undefined output code means port
module ppr_remap #(
  parameter int                     NUM_BIDIR     = 17,
  parameter logic [NUM_BIDIR*7-1:0] BIDIR_PINS    = {7'h78, 7'h76, 7'h61, 7'h39, 7'h38, 7'h37, 7'h36, 7'h2B,
                                                     7'h2A, 7'h29, 7'h28, 7'h27, 7'h26, 7'h25, 7'h24, 7'h23,
                                                     7'h14},
  parameter logic [127:0]           PIN_PRESENT   = 128'h03C00003_C0000000_07F8EFFF_1B100000,
  parameter bit                     MOTOR_VARIANT = 1'b1,
  parameter bit                     CAN_VARIANT   = 1'b1
) (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [`PPR_ADR_W-1:0]     wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [31:0]               wb_dat_i,
  output logic      [31:0]               wb_dat_o,
  output logic                           wb_ack_o,
  input  wire logic [127:0]              pin_in_i,
  input  wire logic                      comparator_one_out_i,
  input  wire logic                      comparator_two_out_i,
  input  wire logic                      comparator_three_out_i,
  input  wire logic                      comparator_four_out_i,
  input  wire logic                      trigger_gen_out_30_i,
  input  wire logic                      trigger_gen_out_31_i,
  input  wire logic                      filtered_encoder_index_i,
  input  wire logic                      filtered_encoder_home_i,
  output logic      [ppr_pkg::PPRI_COUNT-1:0] routed_in_o,
  input  wire logic                      uart_one_transmit_i,
  input  wire logic                      uart_two_transmit_i,
  input  wire logic                      spi_two_data_out_i,
  input  wire logic                      spi_two_clock_out_i,
  input  wire logic                      spi_two_select_out_i,
  input  wire logic                      can_transmit_i,
  input  wire logic                      compare_one_out_i,
  input  wire logic                      compare_two_out_i,
  input  wire logic                      compare_three_out_i,
  input  wire logic                      compare_four_out_i,
  input  wire logic                      pwm_timebase_sync_out_i,
  input  wire logic                      encoder_counter_match_out_i,
  input  wire logic                      reference_clock_out_i,
  input  wire logic [NUM_BIDIR-1:0]      port_data_i,
  input  wire logic [NUM_BIDIR-1:0]      port_oe_i,
  input  wire logic [NUM_BIDIR-1:0]      analog_en_i,
  output logic      [NUM_BIDIR-1:0]      pin_o,
  output logic      [NUM_BIDIR-1:0]      pin_oe_o,
  output logic      [NUM_BIDIR-1:0]      remap_active_o
);

  localparam int NUM_IN = ppr_pkg::PPRI_COUNT;

  if (NUM_BIDIR < 1 || NUM_BIDIR > 32) begin : g_bad_count
    $error("NUM_BIDIR must lie in 1..32");
  end

  ppr_pkg::ppr_isel_t in_sel_ff  [NUM_IN];
  ppr_pkg::ppr_osel_t out_sel_ff [NUM_BIDIR];
  logic               ack_ff;
  logic [31:0]        dat_ff;
  logic [31:0]        nxt_dat;
  logic               req;
  logic               wr_fire;
  logic [63:0]        osrc;
  logic [8:0]         virt;

  function automatic logic [`PPR_ADR_W-1:0] in_adr(input int idx);
    in_adr = `PPR_ADR_W'(`PPR_IN_BASE + 4 * idx);
  endfunction : in_adr

  function automatic logic [`PPR_ADR_W-1:0] out_adr(input int idx);
    out_adr = `PPR_ADR_W'(`PPR_OUT_BASE + 4 * idx);
  endfunction : out_adr

  // motor-only and can-only outputs fall back to the port on other variants
  function automatic logic out_defined(input ppr_pkg::ppr_osel_t code);
    case (code)
      `PPR_OSEL_UART1_TX, `PPR_OSEL_UART2_TX, `PPR_OSEL_SPI_DATA, `PPR_OSEL_SPI_CLK, `PPR_OSEL_SPI_SEL,
      `PPR_OSEL_CMPR1, `PPR_OSEL_CMPR2, `PPR_OSEL_CMPR3, `PPR_OSEL_CMPR4,
      `PPR_OSEL_CMP1, `PPR_OSEL_CMP2, `PPR_OSEL_CMP3, `PPR_OSEL_CMP4, `PPR_OSEL_REFCLK:
        out_defined = 1'b1; // R13 R14 R15 R16
      `PPR_OSEL_CAN_TX:
        out_defined = CAN_VARIANT;
      `PPR_OSEL_TB_SYNC, `PPR_OSEL_ENC_CMP:
        out_defined = MOTOR_VARIANT; // R16
      default:
        out_defined = 1'b0; // R12 R23
    endcase
  endfunction : out_defined

  // virt: {fhome, fidx, trg31, trg30, cmp4, cmp3, cmp2, cmp1, 0}
  function automatic logic in_route(input ppr_pkg::ppr_isel_t code, input logic [127:0] pins,
                                    input logic [8:0] vsrc);
    case (code)
      `PPR_ISEL_GND:
        in_route = 1'b0; // R5
      `PPR_ISEL_CMP1, `PPR_ISEL_CMP2, `PPR_ISEL_CMP3, `PPR_ISEL_CMP4:
        in_route = vsrc[code[2:0]]; // R5 R8
      `PPR_ISEL_TRG30:
        in_route = vsrc[5]; // R5
      `PPR_ISEL_TRG31:
        in_route = vsrc[6]; // R5
      `PPR_ISEL_FIDX:
        in_route = MOTOR_VARIANT & vsrc[7]; // R6
      `PPR_ISEL_FHOME:
        in_route = MOTOR_VARIANT & vsrc[8]; // R6
      default:
        // absent codes read low like the ground selection
        in_route = PIN_PRESENT[code] & pins[code]; // R3 R4 R7 R22
    endcase
  endfunction : in_route

  assign virt = {filtered_encoder_home_i, filtered_encoder_index_i, trigger_gen_out_31_i,
                 trigger_gen_out_30_i, comparator_four_out_i, comparator_three_out_i,
                 comparator_two_out_i, comparator_one_out_i, 1'b0}; // R8

  always_comb
  begin
    osrc                     = '0;
    osrc[`PPR_OSEL_UART1_TX] = uart_one_transmit_i;
    osrc[`PPR_OSEL_UART2_TX] = uart_two_transmit_i;
    osrc[`PPR_OSEL_SPI_DATA] = spi_two_data_out_i;
    osrc[`PPR_OSEL_SPI_CLK]  = spi_two_clock_out_i;
    osrc[`PPR_OSEL_SPI_SEL]  = spi_two_select_out_i;
    osrc[`PPR_OSEL_CAN_TX]   = can_transmit_i;
    osrc[`PPR_OSEL_CMPR1]    = compare_one_out_i;
    osrc[`PPR_OSEL_CMPR2]    = compare_two_out_i;
    osrc[`PPR_OSEL_CMPR3]    = compare_three_out_i;
    osrc[`PPR_OSEL_CMPR4]    = compare_four_out_i;
    osrc[`PPR_OSEL_CMP1]     = comparator_one_out_i;
    osrc[`PPR_OSEL_CMP2]     = comparator_two_out_i;
    osrc[`PPR_OSEL_CMP3]     = comparator_three_out_i;
    osrc[`PPR_OSEL_CMP4]     = comparator_four_out_i;
    osrc[`PPR_OSEL_TB_SYNC]  = pwm_timebase_sync_out_i;
    osrc[`PPR_OSEL_ENC_CMP]  = encoder_counter_match_out_i;
    osrc[`PPR_OSEL_REFCLK]   = reference_clock_out_i;
  end

  // wishbone classic slave: ack one cycle after the request, dropped the next
  assign req     = wb_cyc_i & wb_stb_i;
  assign wr_fire = req & wb_we_i & ack_ff & wb_sel_i[0];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_ff <= 1'b0;
    else
      ack_ff <= req & ~ack_ff;
  end

  always_comb
  begin
    nxt_dat = '0;
    for (int i = 0; i < NUM_IN; i++)
    begin
      if (wb_adr_i == in_adr(i))
        nxt_dat[6:0] = in_sel_ff[i];
    end
    for (int j = 0; j < NUM_BIDIR; j++)
    begin
      if (wb_adr_i == out_adr(j))
        nxt_dat[5:0] = out_sel_ff[j];
    end
    if (wb_adr_i == `PPR_STAT_OFS)
      nxt_dat[NUM_BIDIR-1:0] = remap_active_o;
    if (wb_adr_i == `PPR_LVL_OFS)
      nxt_dat[NUM_IN-1:0] = routed_in_o;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_ff <= '0;
    else if (req & ~ack_ff)
      dat_ff <= nxt_dat;
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;

  // input side: per-peripheral select fields, fully independent of outputs
  for (genvar i = 0; i < NUM_IN; i++) begin : g_in
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
        in_sel_ff[i] <= `PPR_ISEL_RST; // R20
      else if (wr_fire && wb_adr_i == in_adr(i))
        in_sel_ff[i] <= wb_dat_i[6:0]; // R1 R2 R10 R18
    end

    // several inputs may select the same pin; each reads it independently
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
        routed_in_o[i] <= 1'b0;
      else
        routed_in_o[i] <= in_route(in_sel_ff[i], pin_in_i, virt); // R3 R19
    end

    in_trig30_a: assert property (@(posedge clk_i) disable iff (rst_i) // R5
      in_sel_ff[i] == `PPR_ISEL_TRG30 |=> routed_in_o[i] == $past(trigger_gen_out_30_i))
      else $error("trigger output 30 not routed");

    in_trig31_a: assert property (@(posedge clk_i) disable iff (rst_i) // R5
      in_sel_ff[i] == `PPR_ISEL_TRG31 |=> routed_in_o[i] == $past(trigger_gen_out_31_i))
      else $error("trigger output 31 not routed");

    in_fidx_a: assert property (@(posedge clk_i) disable iff (rst_i) // R6
      in_sel_ff[i] == `PPR_ISEL_FIDX |=> routed_in_o[i] == (MOTOR_VARIANT && $past(filtered_encoder_index_i)))
      else $error("filtered index not routed");

    in_fhome_a: assert property (@(posedge clk_i) disable iff (rst_i) // R6
      in_sel_ff[i] == `PPR_ISEL_FHOME |=> routed_in_o[i] == (MOTOR_VARIANT && $past(filtered_encoder_home_i)))
      else $error("filtered home not routed");

    in_cmp4_a: assert property (@(posedge clk_i) disable iff (rst_i) // R8
      in_sel_ff[i] == `PPR_ISEL_CMP4 |=> routed_in_o[i] == $past(comparator_four_out_i))
      else $error("comparator four not routed");
  end

  // output side: per-pin select fields
  for (genvar j = 0; j < NUM_BIDIR; j++) begin : g_out
    logic act;

    assign act = out_defined(out_sel_ff[j]) & ~analog_en_i[j]; // R21

    if (!PIN_PRESENT[BIDIR_PINS[j*7 +: 7]])
    begin : g_bad_pin
      $error("BIDIR_PINS names a pin missing from PIN_PRESENT");
    end

    always_ff @(posedge clk_i)
    begin
      if (rst_i)
        out_sel_ff[j] <= `PPR_OSEL_RST; // R17
      else if (wr_fire && wb_adr_i == out_adr(j))
        out_sel_ff[j] <= wb_dat_i[5:0]; // R1 R11 R18
    end

    // analog owns the pad: neither the port nor a remapped output drives it
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        pin_o[j]          <= 1'b0;
        pin_oe_o[j]       <= 1'b0;
        remap_active_o[j] <= 1'b0;
      end
      else
      begin
        remap_active_o[j] <= act;
        pin_o[j]          <= analog_en_i[j] ? 1'b0 : (act ? osrc[out_sel_ff[j]] : port_data_i[j]); // R21 R19
        pin_oe_o[j]       <= analog_en_i[j] ? 1'b0 : (act | port_oe_i[j]); // R12 R21 R23
      end
    end

    out_compare_a: assert property (@(posedge clk_i) disable iff (rst_i) // R14
      (out_sel_ff[j] == `PPR_OSEL_CMPR1 && !analog_en_i[j])
        |=> pin_oe_o[j] && pin_o[j] == $past(compare_one_out_i))
      else $error("compare output not on pin");

    out_comp1_a: assert property (@(posedge clk_i) disable iff (rst_i) // R15
      (out_sel_ff[j] == `PPR_OSEL_CMP1 && !analog_en_i[j])
        |=> remap_active_o[j] && pin_o[j] == $past(comparator_one_out_i))
      else $error("comparator one not on pin");

    out_comp4_a: assert property (@(posedge clk_i) disable iff (rst_i) // R15
      (out_sel_ff[j] == `PPR_OSEL_CMP4 && !analog_en_i[j])
        |=> remap_active_o[j] && pin_o[j] == $past(comparator_four_out_i))
      else $error("comparator four not on pin");

    out_spi_a: assert property (@(posedge clk_i) disable iff (rst_i) // R13
      (out_sel_ff[j] == `PPR_OSEL_SPI_CLK && !analog_en_i[j])
        |=> pin_oe_o[j] && pin_o[j] == $past(spi_two_clock_out_i))
      else $error("spi clock not on pin");

    out_refclk_a: assert property (@(posedge clk_i) disable iff (rst_i) // R16
      (out_sel_ff[j] == `PPR_OSEL_REFCLK && !analog_en_i[j])
        |=> pin_oe_o[j] && pin_o[j] == $past(reference_clock_out_i))
      else $error("reference clock not on pin");

    out_can_a: assert property (@(posedge clk_i) disable iff (rst_i) // R13
      (out_sel_ff[j] == `PPR_OSEL_CAN_TX && !analog_en_i[j])
        |=> remap_active_o[j] == CAN_VARIANT)
      else $error("can transmit ownership wrong");

    out_sync_a: assert property (@(posedge clk_i) disable iff (rst_i) // R16
      (out_sel_ff[j] == `PPR_OSEL_TB_SYNC && !analog_en_i[j])
        |=> remap_active_o[j] == MOTOR_VARIANT)
      else $error("time base sync ownership wrong");
  end

  logic pin_of_sel0;
  logic wr_in0;
  assign pin_of_sel0 = pin_in_i[in_sel_ff[0]];
  assign wr_in0      = wr_fire && wb_adr_i == in_adr(0);

  ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  ack_answer_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !wb_ack_o) |=> wb_ack_o)
    else $error("request not answered in one cycle");

  sel_lane_a: assert property (@(posedge clk_i) disable iff (rst_i) // R2
    (req && wb_we_i && !wb_sel_i[0] && wb_adr_i == in_adr(0)) |=> $stable(in_sel_ff[0]))
    else $error("write without low lane changed select");

  rd_data_a: assert property (@(posedge clk_i) disable iff (rst_i) // R2
    (req && !wb_ack_o && wb_adr_i == in_adr(0)) |=> wb_dat_o == {25'h0, $past(in_sel_ff[0])})
    else $error("select read back wrong");

  in_write_a: assert property (@(posedge clk_i) disable iff (rst_i) // R2
    wr_in0 |=> in_sel_ff[0] == $past(wb_dat_i[6:0]))
    else $error("input select write lost");

  in_ground_a: assert property (@(posedge clk_i) disable iff (rst_i) // R5
    in_sel_ff[0] == `PPR_ISEL_GND ##1 in_sel_ff[0] == `PPR_ISEL_GND |-> !routed_in_o[0])
    else $error("ground selection not low");

  in_pin_a: assert property (@(posedge clk_i) disable iff (rst_i) // R3
    (in_sel_ff[0] > `PPR_ISEL_FHOME && PIN_PRESENT[in_sel_ff[0]]) |=> routed_in_o[0] == $past(pin_of_sel0))
    else $error("pin not routed to input");

  in_absent_a: assert property (@(posedge clk_i) disable iff (rst_i) // R22
    (in_sel_ff[0] > `PPR_ISEL_FHOME && !PIN_PRESENT[in_sel_ff[0]]) |=> !routed_in_o[0])
    else $error("absent source not low");

  in_virtual_a: assert property (@(posedge clk_i) disable iff (rst_i) // R8
    in_sel_ff[0] == `PPR_ISEL_CMP1 |=> routed_in_o[0] == $past(comparator_one_out_i))
    else $error("virtual comparator path broken");

  in_many_a: assert property (@(posedge clk_i) disable iff (rst_i) // R19
    in_sel_ff[0] == in_sel_ff[1] |=> routed_in_o[0] == routed_in_o[1])
    else $error("shared pin read differently");

  out_reset_a: assert property (@(posedge clk_i) disable iff (rst_i) // R17
    $fell(rst_i) |-> out_sel_ff[0] == `PPR_OSEL_RST && !remap_active_o[0])
    else $error("output select not zero after reset");

  out_port_a: assert property (@(posedge clk_i) disable iff (rst_i) // R12
    (!out_defined(out_sel_ff[0]) && !analog_en_i[0])
      |=> pin_o[0] == $past(port_data_i[0]) && pin_oe_o[0] == $past(port_oe_i[0]))
    else $error("port function not kept");

  out_uart_a: assert property (@(posedge clk_i) disable iff (rst_i) // R13
    (out_sel_ff[0] == `PPR_OSEL_UART1_TX && !analog_en_i[0])
      |=> pin_oe_o[0] && remap_active_o[0] && pin_o[0] == $past(uart_one_transmit_i))
    else $error("uart transmit not on pin");

  out_analog_a: assert property (@(posedge clk_i) disable iff (rst_i) // R21
    analog_en_i[0] |=> !pin_oe_o[0] && !remap_active_o[0])
    else $error("remap overrode analog");

endmodule : ppr_remap

`default_nettype wire

/* tb/ppr_far_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ppr_far_model (
  input  wire logic [63:0]  pat_i,
  output logic      [127:0] pin_in_o,
  output logic      [7:0]   vsrc_o,
  output logic      [12:0]  osrc_o,
  output logic      [16:0]  port_data_o,
  output logic      [16:0]  port_oe_o,
  output logic      [16:0]  analog_en_o
);
  // upper pads mirror lower ones inverted so code n and code n+64 never share a level
  assign pin_in_o    = {pat_i, ~pat_i};
  assign vsrc_o[5:0] = pat_i[5:0];
  // filter only meaningful behind a real pad
  assign vsrc_o[7:6] = {pin_in_o[43], pin_in_o[37]};
  assign osrc_o      = pat_i[18:6];
  assign port_data_o = pat_i[35:19];
  assign port_oe_o   = pat_i[52:36];
  // about one pin in eight claimed by analog
  assign analog_en_o = pat_i[16:0] & pat_i[33:17] & pat_i[50:34];
endmodule : ppr_far_model
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ppr_consts.svh"
module tb;
  localparam logic [127:0] PRESENT = 128'h03C00003_C0000000_07F8EFFF_1B100000;
  logic        clk_i, rst_i, cyc, stb, we, ack;
  logic [8:0]  adr;
  logic [3:0]  sel;
  logic [3:0]  sel_v = 4'hF;
  logic [31:0] wdat, rdat, note;
  logic [63:0] pat;
  logic [127:0] pin_in;
  logic [7:0]  vs;
  logic [12:0] os;
  logic [16:0] pd, poe, ana, pin, oe, act;
  logic [23:0] routed;
  logic [6:0]  isel [24];
  logic [5:0]  osel [17];
  logic [31:0] notes [$];
  int          num_errors = 0;
  int          cmp_count = 0;
  int          seed = 58;

  ppr_far_model far (.pat_i(pat), .pin_in_o(pin_in), .vsrc_o(vs), .osrc_o(os),
    .port_data_o(pd), .port_oe_o(poe), .analog_en_o(ana));

  ppr_remap #(.PIN_PRESENT(PRESENT)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .pin_in_i(pin_in), .comparator_one_out_i(vs[0]), .comparator_two_out_i(vs[1]),
    .comparator_three_out_i(vs[2]), .comparator_four_out_i(vs[3]), .trigger_gen_out_30_i(vs[4]),
    .trigger_gen_out_31_i(vs[5]), .filtered_encoder_index_i(vs[6]), .filtered_encoder_home_i(vs[7]),
    .routed_in_o(routed), .uart_one_transmit_i(os[0]), .uart_two_transmit_i(os[1]),
    .spi_two_data_out_i(os[2]), .spi_two_clock_out_i(os[3]), .spi_two_select_out_i(os[4]),
    .can_transmit_i(os[5]), .compare_one_out_i(os[6]), .compare_two_out_i(os[7]),
    .compare_three_out_i(os[8]), .compare_four_out_i(os[9]), .pwm_timebase_sync_out_i(os[10]),
    .encoder_counter_match_out_i(os[11]), .reference_clock_out_i(os[12]), .port_data_i(pd),
    .port_oe_i(poe), .analog_en_i(ana), .pin_o(pin), .pin_oe_o(oe), .remap_active_o(act));

  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic tally_and_finish();
    if (num_errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  task automatic bus(input logic [8:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_i);
    {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, sel_v};
    @(posedge clk_i);
    while (ack !== 1'b1)
      @(posedge clk_i);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus

  task automatic rd(input logic [8:0] a, input logic [31:0] e);
    notes.push_back(e);
    bus(a, 1'b0, 32'h0);
  endtask : rd

  task automatic setin(input int i, input logic [6:0] c);
    isel[i] = c;
    bus(9'(`PPR_IN_BASE + 4 * i), 1'b1, {$random(seed)} & 32'hFFFFFF80 | c);
    rd(9'(`PPR_IN_BASE + 4 * i), {25'h0, c});
  endtask : setin

  task automatic setout(input int j, input logic [5:0] c);
    osel[j] = c;
    bus(9'(`PPR_OUT_BASE + 4 * j), 1'b1, {$random(seed)} & 32'hFFFFFFC0 | c);
    rd(9'(`PPR_OUT_BASE + 4 * j), {26'h0, c});
  endtask : setout

  task automatic newpat();
    @(posedge clk_i);
    pat <= {$random(seed), $random(seed)};
  endtask : newpat

  function automatic logic [31:0] lvl();
    logic [31:0] r;
    logic [6:0]  c;
    r = 32'h0;
    for (int i = 0; i < 24; i++)
    begin
      c = isel[i];
      if (c >= 7'h01 && c <= 7'h04) r[i] = vs[c - 7'h01];
      else if (c >= 7'h06 && c <= 7'h09) r[i] = vs[c - 7'h02];
      else if (c >= 7'h0A) r[i] = PRESENT[c] & pin_in[c];
    end
    return r;
  endfunction : lvl

  function automatic logic [50:0] outs();
    logic [16:0] a, e, p;
    logic        s, h;
    for (int j = 0; j < 17; j++)
    begin
      h = 1'b1;
      s = pd[j];
      case (osel[j])
        6'h01: s = os[0];
        6'h03: s = os[1];
        6'h08, 6'h09, 6'h0A: s = os[osel[j] - 6'h06];
        6'h0E: s = os[5];
        6'h10, 6'h11, 6'h12, 6'h13: s = os[osel[j] - 6'h0A];
        6'h18, 6'h19, 6'h1A: s = vs[osel[j] - 6'h18];
        6'h2D: s = os[10];
        6'h2F: s = os[11];
        6'h31: s = os[12];
        6'h32: s = vs[3];
        default: h = 1'b0;
      endcase
      a[j] = h & ~ana[j];
      e[j] = (h | poe[j]) & ~ana[j];
      p[j] = s & e[j];
    end
    return {a, e, p};
  endfunction : outs

  task automatic chk_pins();
    logic [50:0] x;
    repeat (3) @(posedge clk_i);
    x = outs();
    cmp_count++;
    if ({act, oe, pin & oe} !== x)
    begin
      num_errors++;
      $display("[FAIL] %0t pins %h exp %h", $time, {act, oe, pin & oe}, x);
    end
    rd(`PPR_STAT_OFS, {15'h0, x[50:34]});
  endtask : chk_pins

  always @(posedge clk_i)
    if (ack === 1'b1 && we === 1'b0)
    begin
      cmp_count++;
      note = notes.size() ? notes.pop_front() : 32'hXXXXXXXX;
      if (rdat !== note)
      begin
        num_errors++;
        $display("[FAIL] %0t rd %h exp %h", $time, rdat, note);
      end
    end

  initial
  begin
    #100000;
    num_errors++;
    tally_and_finish();
  end

  initial
  begin
    {rst_i, cyc, stb, we, adr, sel, wdat, pat} = {1'b1, 112'h0};
    foreach (isel[i]) isel[i] = 7'h00;
    foreach (osel[j]) osel[j] = 6'h00;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    newpat();
    chk_pins();
    for (int i = 0; i < 24; i++) rd(9'(`PPR_IN_BASE + 4 * i), 32'h0);
    for (int j = 0; j < 17; j++) rd(9'(`PPR_OUT_BASE + 4 * j), 32'h0);
    rd(`PPR_LVL_OFS, lvl());
    rd(9'h1FC, 32'h0);
    for (int i = 0; i < 24; i++) setin(i, 7'h14);
    rd(`PPR_LVL_OFS, lvl());
    for (int c = 0; c < 128; c++)
    begin
      setin(c % 24, c[6:0]);
      repeat (2)
      begin
        newpat();
        repeat (2) @(posedge clk_i);
        rd(`PPR_LVL_OFS, lvl());
      end
    end
    for (int c = 0; c < 64; c++)
    begin
      setout(c % 17, c[5:0]);
      repeat (2)
      begin
        newpat();
        chk_pins();
      end
    end
    for (int j = 0; j < 17; j++) setout(j, 6'h01);
    newpat();
    chk_pins();
    rd(`PPR_LVL_OFS, lvl());
    sel_v = 4'hE;
    bus(`PPR_IN_BASE, 1'b1, 32'h55);
    sel_v = 4'hF;
    rd(`PPR_IN_BASE, {25'h0, isel[0]});
    setin(0, 7'h01);
    newpat();
    repeat (2) @(posedge clk_i);
    rd(`PPR_LVL_OFS, lvl());
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
